//--- pkg/dfs_pkg.sv
package dfs_pkg;

  // ==========================================================
  // access port widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  // ==========================================================
  // parameter / holding register addresses
  localparam logic [15:0] OFF_ANA_ONE_PCT = 16'h0076;
  localparam logic [15:0] OFF_CMD_MIRROR = 16'h012D;
  localparam logic [15:0] OFF_STAT_MIRROR = 16'h012E;
  localparam logic [15:0] OFF_FAULT_ONE = 16'h0131;
  localparam logic [15:0] OFF_FAULT_TWO = 16'h0132;
  localparam logic [15:0] OFF_ALARM_ONE = 16'h0134;
  localparam logic [15:0] OFF_ALARM_TWO = 16'h0135;
  localparam logic [15:0] OFF_ACT_ONE = 16'h9C45;
  localparam logic [15:0] OFF_ACT_TWO = 16'h9C46;

  // ==========================================================
  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [6:0] RST_PCT = 7'h00;

  // ==========================================================
  // fault word one bit positions
  localparam int FLT1_OVERCURRENT = 0;
  localparam int FLT1_DC_OVERVOLT = 1;
  localparam int FLT1_DRIVE_OVERTEMP = 2;
  localparam int FLT1_FAULT_CURRENT = 3;
  localparam int FLT1_OUT_OVERLOAD = 4;
  localparam int FLT1_DC_UNDERVOLT = 5;
  localparam int FLT1_ANA_ONE_FAULT = 6;
  localparam int FLT1_AI2_FAULT = 7;
  localparam int FLT1_MOTOR_OVERTEMP = 8;
  localparam int FLT1_PANEL_LOSS = 9;
  localparam int FLT1_PARAM_INCONS = 10;
  localparam int FLT1_DC_RIPPLE = 11;
  localparam int FLT1_MOTOR_STALL = 12;
  localparam int FLT1_SERIAL_LOSS = 13;
  localparam int FLT1_EXT_FAULT = 14;
  localparam int FLT1_GROUND_FAULT = 15;
  // fault word two bit positions, 1, 3 to 7 and 9 to 15 reserved
  localparam int FLT2_UNDERLOAD = 0;
  localparam int FLT2_OPTICAL_LINK = 2;
  localparam int FLT2_HW_ERROR = 8;

  // ==========================================================
  // alarm word one bit positions, 14 and 15 reserved
  localparam int ALM1_OVERCURRENT = 0;
  localparam int ALM1_OVERVOLT = 1;
  localparam int ALM1_UNDERVOLT = 2;
  localparam int ALM1_DIR_LOCK = 3;
  localparam int ALM1_SERIAL_LOSS = 4;
  localparam int ALM1_MODBUS_EXC = 5;
  localparam int ALM1_ANA_ONE_LOSS = 6;
  localparam int ALM1_AI2_LOSS = 7;
  localparam int ALM1_PANEL_LOSS = 8;
  localparam int ALM1_DRIVE_OVERTEMP = 9;
  localparam int ALM1_MOTOR_OVERTEMP = 10;
  localparam int ALM1_UNDERLOAD = 11;
  localparam int ALM1_MOTOR_STALL = 12;
  localparam int ALM1_OPTICAL_LINK = 13;
  // alarm word two bit positions, 5 and up reserved
  localparam int ALM2_OVERLOAD = 0;
  localparam int ALM2_AUTORESET = 1;
  localparam int ALM2_CTRL_SLEEP = 2;
  localparam int ALM2_PUMP_AUTOCHANGE = 3;
  localparam int ALM2_PUMP_INTERLOCK = 4;

  localparam logic [15:0] FAULT_ONE_MASK = 16'hFFFF;
  localparam logic [15:0] FAULT_TWO_MASK = 16'((1 << FLT2_UNDERLOAD) |
      (1 << FLT2_OPTICAL_LINK) | (1 << FLT2_HW_ERROR));
  localparam logic [15:0] ALARM_ONE_MASK = 16'((1 << (ALM1_OPTICAL_LINK + 1)) - 1);
  localparam logic [15:0] ALARM_TWO_MASK = 16'((1 << (ALM2_PUMP_INTERLOCK + 1)) - 1);

  // ==========================================================
  // reference correction
  typedef enum logic [1:0] {
    SRC_FIELDBUS = 2'h0,
    SRC_SUM = 2'h1,
    SRC_SCALED = 2'h2
  } dfs_src_t;

  localparam logic [6:0] PCT_MAX = 7'h64;
  localparam int REF_FULL_SCALE = 20000;
  localparam logic signed [31:0] PCT_DIV = 32'sh0000_0064;
  localparam logic signed [31:0] REF_PER_PCT = 32'(REF_FULL_SCALE / 100);
  localparam logic signed [31:0] SAT_HI = 32'sh0000_7FFF;
  localparam logic signed [31:0] SAT_LO = -32'sh0000_8000;

endpackage : dfs_pkg

//--- design/dfs_ref_correct.sv
`timescale 1ns/1ps
`default_nettype none
module dfs_ref_correct import dfs_pkg::*; (
  input wire logic sys_clk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic signed [15:0] fbRef, // received fieldbus reference
  input wire logic [6:0] anaOnePct, // analog input one, 0..100 percent
  input wire logic [1:0] srcSel, // reference source select
  output logic signed [15:0] corrRef // corrected reference
);

  typedef struct packed {
    logic signed [15:0] corrRef;
  } dfs_corr_state_t;

  dfs_corr_state_t state_r;
  dfs_corr_state_t state_nxt;

  // ==========================================================
  // correction arithmetic
  function automatic logic signed [15:0] corr_calc(input logic signed [15:0] fbIn,
                                                   input logic [6:0] pct,
                                                   input logic [1:0] sel);
    logic signed [31:0] wide;
    logic signed [31:0] pctS;
    pctS = $signed({25'h0, pct});
    case (sel)
      SRC_SUM: wide = 32'(fbIn) + pctS * REF_PER_PCT;
      // signed divide truncates toward zero, symmetric for reverse direction
      SRC_SCALED: wide = (32'(fbIn) * pctS) / PCT_DIV;
      default: wide = 32'(fbIn);
    endcase
    // sum may pass the word range, so clip instead of wrapping
    if (wide > SAT_HI) begin
      wide = SAT_HI;
    end else if (wide < SAT_LO) begin
      wide = SAT_LO;
    end
    return wide[15:0];
  endfunction : corr_calc

  always_comb begin
    state_nxt = state_r;
    state_nxt.corrRef = corr_calc(fbRef, anaOnePct, srcSel);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign corrRef = state_r.corrRef;

endmodule : dfs_ref_correct
`default_nettype wire

//--- design/dfs_status_bank.sv
`timescale 1ns/1ps
`default_nettype none
module dfs_status_bank import dfs_pkg::*; (
  input wire logic sys_clk, // system clock, 20 MHz
  input wire logic arst_n, // async reset, active low
  // parameter access from the serial link engine
  input wire logic [15:0] regAddr, // parameter / holding register number
  input wire logic regWrEn, // write strobe, one cycle
  input wire logic [15:0] regWrData, // write data
  input wire logic regRdEn, // read strobe, one cycle
  output logic [15:0] regRdData, // read data, valid with regRdValid
  output logic regRdValid, // read answer pulse
  output logic regWrAck, // write accepted pulse
  output logic regAccessErr, // unmapped or refused access pulse
  // reference path
  input wire logic signed [15:0] fbRefOne, // fieldbus reference one
  input wire logic signed [15:0] fbRefTwo, // fieldbus reference two
  input wire logic [1:0] refOneSel, // reference_one_source_select
  input wire logic [1:0] refTwoSel, // reference_two_source_select
  input wire logic [6:0] anaOneLevel, // analog input one, percent
  output logic signed [15:0] corrRefOne, // corrected reference one
  output logic signed [15:0] corrRefTwo, // corrected reference two
  // drive state sources
  input wire logic [15:0] ctrlWord, // current control word
  input wire logic [15:0] statWord, // current status word
  input wire logic actOneNeg, // actual value one sign
  input wire logic [14:0] actOneMag, // actual value one magnitude
  input wire logic actTwoNeg, // actual value two sign
  input wire logic [14:0] actTwoMag, // actual value two magnitude
  input wire logic [15:0] faultCondOne, // active faults, word one
  input wire logic [15:0] faultCondTwo, // active faults, word two
  input wire logic [15:0] alarmCondOne, // active alarms, word one
  input wire logic [15:0] alarmCondTwo // active alarms, word two
);

  typedef struct packed {
    logic [15:0] rdData;
    logic rdValid;
    logic wrAck;
    logic accessErr;
    logic [6:0] anaOnePct;
    logic [15:0] cmdMirror;
    logic [15:0] statMirror;
    logic [15:0] faultOne;
    logic [15:0] faultTwo;
    logic [15:0] alarmOne;
    logic [15:0] alarmTwo;
    logic [15:0] actOne;
    logic [15:0] actTwo;
  } dfs_bank_state_t;

  dfs_bank_state_t state_r;
  dfs_bank_state_t state_nxt;

  // ==========================================================
  // helpers
  function automatic logic [15:0] signed_word(input logic neg, input logic [14:0] mag);
    logic [15:0] pos;
    pos = {1'b0, mag};
    return neg ? 16'(-pos) : pos;
  endfunction : signed_word

  function automatic logic is_mapped(input logic [15:0] addr);
    return (addr == OFF_ANA_ONE_PCT) || (addr == OFF_CMD_MIRROR) ||
           (addr == OFF_STAT_MIRROR) || (addr == OFF_FAULT_ONE) ||
           (addr == OFF_FAULT_TWO) || (addr == OFF_ALARM_ONE) ||
           (addr == OFF_ALARM_TWO) || (addr == OFF_ACT_ONE) ||
           (addr == OFF_ACT_TWO);
  endfunction : is_mapped

  function automatic logic [15:0] read_mux(input dfs_bank_state_t s, input logic [15:0] addr);
    logic [15:0] d;
    d = RST_WORD;
    unique case (addr)
      OFF_ANA_ONE_PCT: d = {9'h0, s.anaOnePct};
      OFF_CMD_MIRROR: d = s.cmdMirror;
      OFF_STAT_MIRROR: d = s.statMirror;
      OFF_FAULT_ONE: d = s.faultOne;
      OFF_FAULT_TWO: d = s.faultTwo;
      OFF_ALARM_ONE: d = s.alarmOne;
      OFF_ALARM_TWO: d = s.alarmTwo;
      OFF_ACT_ONE: d = s.actOne;
      OFF_ACT_TWO: d = s.actTwo;
      default: d = RST_WORD;
    endcase
    return d;
  endfunction : read_mux

  // ==========================================================
  // reference correction, one per external reference
  dfs_ref_correct u_corr_one (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .fbRef(fbRefOne),
    .anaOnePct(state_r.anaOnePct),
    .srcSel(refOneSel),
    .corrRef(corrRefOne)
  );

  dfs_ref_correct u_corr_two (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .fbRef(fbRefTwo),
    .anaOnePct(state_r.anaOnePct),
    .srcSel(refTwoSel),
    .corrRef(corrRefTwo)
  );

  // ==========================================================
  // next state
  logic clrAlarmOne;
  logic clrAlarmTwo;
  logic wrAllowed;

  always_comb begin
    // only a zero written to an alarm word is taken; everything else is refused
    clrAlarmOne = regWrEn && (regAddr == OFF_ALARM_ONE) && (regWrData == RST_WORD);
    clrAlarmTwo = regWrEn && (regAddr == OFF_ALARM_TWO) && (regWrData == RST_WORD);
    wrAllowed = clrAlarmOne || clrAlarmTwo;

    state_nxt = state_r;
    // converter may overshoot full scale, keep the parameter inside 0..100
    state_nxt.anaOnePct = (anaOneLevel > PCT_MAX) ? PCT_MAX : anaOneLevel;
    state_nxt.cmdMirror = ctrlWord;
    state_nxt.statMirror = statWord;
    state_nxt.actOne = signed_word(actOneNeg, actOneMag);
    state_nxt.actTwo = signed_word(actTwoNeg, actTwoMag);
    state_nxt.faultOne = faultCondOne & FAULT_ONE_MASK;
    state_nxt.faultTwo = faultCondTwo & FAULT_TWO_MASK;

    // a still-active alarm survives its own clear: set wins
    state_nxt.alarmOne = ((clrAlarmOne ? RST_WORD : state_r.alarmOne) | alarmCondOne) &
                         ALARM_ONE_MASK;
    state_nxt.alarmTwo = ((clrAlarmTwo ? RST_WORD : state_r.alarmTwo) | alarmCondTwo) &
                         ALARM_TWO_MASK;

    state_nxt.rdValid = regRdEn;
    state_nxt.rdData = regRdEn ? read_mux(state_r, regAddr) : RST_WORD;
    state_nxt.wrAck = wrAllowed;
    state_nxt.accessErr = (regRdEn && !is_mapped(regAddr)) ||
                          (regWrEn && !wrAllowed);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign regRdData = state_r.rdData;
  assign regRdValid = state_r.rdValid;
  assign regWrAck = state_r.wrAck;
  assign regAccessErr = state_r.accessErr;

endmodule : dfs_status_bank
`default_nettype wire

//--- tb/dfs_status_bank_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checks for the status bank
module dfs_status_bank_asserts import dfs_pkg::*; (
  input wire logic sys_clk, // clock
  input wire logic arst_n, // reset
  input wire logic [15:0] regAddr, // address
  input wire logic regWrEn, // write strobe
  input wire logic [15:0] regWrData, // write data
  input wire logic regRdEn, // read strobe
  input wire logic [15:0] regRdData, // read data
  input wire logic regRdValid, // read answer
  input wire logic regWrAck, // write taken
  input wire logic regAccessErr, // refused
  input wire logic signed [15:0] fbRefOne, // reference one
  input wire logic signed [15:0] fbRefTwo, // reference two
  input wire logic [1:0] refOneSel, // select one
  input wire logic [1:0] refTwoSel, // select two
  input wire logic [6:0] anaOneLevel, // analog percent
  input wire logic signed [15:0] corrRefOne, // corrected one
  input wire logic signed [15:0] corrRefTwo, // corrected two
  input wire logic [15:0] ctrlWord, // control word
  input wire logic [15:0] faultCondOne, // faults one
  input wire logic [15:0] alarmCondOne // alarms one
);
  // words still hold reset zeros at the first edge, so history checks skip it
  logic live_r;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) live_r <= 1'b0;
    else live_r <= 1'b1;
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  property p_refuse;
    regWrEn && !(regWrData == 16'h0000 && (regAddr == OFF_ALARM_ONE || regAddr == OFF_ALARM_TWO))
      |=> regAccessErr && !regWrAck;
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused write not flagged");
  property p_clear;
    regWrEn && regWrData == 16'h0000 && regAddr == OFF_ALARM_TWO |=> regWrAck && !regAccessErr;
  endproperty
  a_clear: assert property (p_clear) else $error("alarm clear not taken");
  property p_sticky;
    live_r && regRdEn && regAddr == OFF_ALARM_ONE && $past(alarmCondOne[0]) |=> regRdData[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("alarm bit lost");
  property p_fault;
    live_r && regRdEn && regAddr == OFF_FAULT_ONE |=> regRdData == $past(faultCondOne, 2);
  endproperty
  a_fault: assert property (p_fault) else $error("fault word wrong");
  property p_mirror;
    live_r && regRdEn && regAddr == OFF_CMD_MIRROR |=> regRdData == $past(ctrlWord, 2);
  endproperty
  a_mirror: assert property (p_mirror) else $error("command mirror wrong");
  property p_mask;
    regRdEn && regAddr == OFF_FAULT_TWO |=> (regRdData & ~FAULT_TWO_MASK) == 16'h0000;
  endproperty
  a_mask: assert property (p_mask) else $error("reserved fault bit set");
  property p_fbonly;
    refOneSel == SRC_FIELDBUS |=> corrRefOne == $past(fbRefOne);
  endproperty
  a_fbonly: assert property (p_fbonly) else $error("analog leaked into reference");
  property p_sum;
    live_r && refTwoSel == SRC_SUM && anaOneLevel == $past(anaOneLevel)
      && anaOneLevel <= PCT_MAX && fbRefTwo < 16'sd10000 && fbRefTwo > -16'sd10000
      |=> corrRefTwo == 16'($past(fbRefTwo) + 16'($past(anaOneLevel)) * 16'sd200);
  endproperty
  a_sum: assert property (p_sum) else $error("sum correction wrong");
  c_clear: cover property (regWrAck);
  c_refuse: cover property (regAccessErr);
  c_read: cover property (regRdValid);
endmodule : dfs_status_bank_asserts
bind dfs_status_bank dfs_status_bank_asserts u_dfs_status_bank_asserts (.*);
`default_nettype wire

//--- tb/dfs_link_master.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// external control system: the only path to the status words
module dfs_link_master (
  input wire logic sys_clk, // clock
  output logic [15:0] regAddr, // address
  output logic regWrEn, // write strobe
  output logic [15:0] regWrData, // write data
  output logic regRdEn, // read strobe
  input wire logic [15:0] regRdData, // read data
  input wire logic regRdValid, // read answer
  input wire logic regWrAck, // write taken
  input wire logic regAccessErr // refused
);
  initial begin
    regAddr = 16'hFFFF;
    regWrData = 16'hFFFF;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic [2:0] f);
    @(posedge sys_clk);
    #1;
    regAddr = a;
    regWrData = d;
    regWrEn = w;
    regRdEn = !w;
    @(posedge sys_clk);
    #1;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    // idle lines are inverted so stale values cannot pass
    regAddr = ~a;
    regWrData = ~d;
    q = regRdData;
    f = {regRdValid, regWrAck, regAccessErr};
  endtask : xfer
endmodule : dfs_link_master
`default_nettype wire

//--- tb/test_dfs_status_bank.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// status bank bench
module test_dfs_status_bank import dfs_pkg::*; ();
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] regAddr, regWrData, regRdData, ctrlWord, statWord;
  logic [15:0] faultCondOne, faultCondTwo, alarmCondOne, alarmCondTwo;
  logic regWrEn, regRdEn, regRdValid, regWrAck, regAccessErr, actOneNeg, actTwoNeg;
  logic signed [15:0] fbRefOne, fbRefTwo, corrRefOne, corrRefTwo;
  logic [1:0] refOneSel, refTwoSel;
  logic [6:0] anaOneLevel;
  logic [14:0] actOneMag, actTwoMag;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  dfs_status_bank u_dfs_status_bank (.*);
  dfs_link_master u_dfs_link_master (.*);
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails = fails + 1;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    n_checks++;
    if (got !== ex) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask : step
  // flags are {read answer, write ack, refused}
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                     input logic [15:0] ex, input logic [2:0] fx);
    logic [15:0] q;
    logic [2:0] f;
    u_dfs_link_master.xfer(w, a, d, q, f);
    chk("data", ex, q);
    chk("flags", 16'(fx), 16'(f));
  endtask : acc
  task automatic t_reset();
    logic [15:0] adr [9] = '{OFF_ANA_ONE_PCT, OFF_CMD_MIRROR, OFF_STAT_MIRROR, OFF_FAULT_ONE,
        OFF_FAULT_TWO, OFF_ALARM_ONE, OFF_ALARM_TWO, OFF_ACT_ONE, OFF_ACT_TWO};
    foreach (adr[i]) begin
      acc(1'b1, adr[i], 16'h1234, 16'h0000, 3'b001);
      acc(1'b0, adr[i], 16'h0000, RST_WORD, 3'b100);
    end
    acc(1'b0, 16'h0133, 16'h0000, 16'h0000, 3'b101);
  endtask : t_reset
  task automatic t_words();
    ctrlWord = 16'hA5C3;
    statWord = 16'h5A3C;
    {actOneNeg, actOneMag, actTwoNeg, actTwoMag} = {1'b1, 15'h0005, 1'b0, 15'h7FFF};
    {faultCondOne, faultCondTwo} = {16'hFFFF, 16'hFFFF};
    acc(1'b0, OFF_CMD_MIRROR, 16'h0000, 16'hA5C3, 3'b100);
    acc(1'b1, OFF_CMD_MIRROR, 16'h0000, 16'h0000, 3'b001);
    acc(1'b0, OFF_STAT_MIRROR, 16'h0000, 16'h5A3C, 3'b100);
    acc(1'b0, OFF_ACT_ONE, 16'h0000, 16'hFFFB, 3'b100);
    acc(1'b0, OFF_ACT_TWO, 16'h0000, 16'h7FFF, 3'b100);
    acc(1'b0, OFF_FAULT_ONE, 16'h0000, 16'hFFFF, 3'b100);
    acc(1'b0, OFF_FAULT_TWO, 16'h0000, 16'h0105, 3'b100);
    actOneMag = 15'h7FFF;
    faultCondOne = 16'h0000;
    acc(1'b0, OFF_ACT_ONE, 16'h0000, 16'h8001, 3'b100);
    acc(1'b0, OFF_FAULT_ONE, 16'h0000, 16'h0000, 3'b100);
  endtask : t_words
  task automatic t_alarms();
    logic [15:0] adr [2] = '{OFF_ALARM_ONE, OFF_ALARM_TWO};
    logic [15:0] msk [2] = '{16'h3FFF, 16'h001F};
    foreach (adr[i]) begin
      {alarmCondOne, alarmCondTwo} = {2{16'hFFFF}};
      step();
      {alarmCondOne, alarmCondTwo} = {2{16'h0000}};
      acc(1'b0, adr[i], 16'h0000, msk[i], 3'b100);
      acc(1'b1, adr[i], 16'h0001, 16'h0000, 3'b001);
      acc(1'b0, adr[i], 16'h0000, msk[i], 3'b100);
      {alarmCondOne, alarmCondTwo} = {2{16'h0001}};
      acc(1'b1, adr[i], 16'h0000, 16'h0000, 3'b010);
      acc(1'b0, adr[i], 16'h0000, 16'h0001, 3'b100);
      {alarmCondOne, alarmCondTwo} = {2{16'h0000}};
      acc(1'b1, adr[i], 16'h0000, 16'h0000, 3'b010);
      acc(1'b0, adr[i], 16'h0000, 16'h0000, 3'b100);
    end
  endtask : t_alarms
  task automatic t_ref();
    // select, reference, percent, expected
    int t [8][4] = '{'{0, 5000, 30, 5000}, '{1, 5000, 30, 11000}, '{2, 5000, 30, 1500},
        '{3, 5000, 30, 5000}, '{1, 30000, 100, 32767}, '{2, -5000, 30, -1500},
        '{2, 20000, 120, 20000}, '{1, -30000, 100, -10000}};
    foreach (t[i]) begin
      step();
      {refOneSel, refTwoSel} = {2'(t[i][0]), 2'(t[i][0])};
      {fbRefOne, fbRefTwo} = {16'(t[i][1]), 16'(t[i][1])};
      anaOneLevel = 7'(t[i][2]);
      repeat (2) @(posedge sys_clk);
      #1;
      chk("corrRefOne", 16'(t[i][3]), corrRefOne);
      chk("corrRefTwo", 16'(t[i][3]), corrRefTwo);
      acc(1'b0, OFF_ANA_ONE_PCT, 16'h0000, 16'(t[i][2] > 100 ? 100 : t[i][2]), 3'b100);
    end
  endtask : t_ref
  initial begin
    {ctrlWord, statWord, faultCondOne, faultCondTwo, alarmCondOne, alarmCondTwo} = '0;
    {actOneNeg, actOneMag, actTwoNeg, actTwoMag} = '0;
    {fbRefOne, fbRefTwo, refOneSel, refTwoSel, anaOneLevel} = '0;
    repeat (12) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    t_reset();
    t_words();
    t_alarms();
    t_ref();
    report_and_stop();
  end
endmodule : test_dfs_status_bank
`default_nettype wire
